// ### src/trr_ctrl.sv
/*
 * Host register block of the station controller: identifiers, soft reset,
 * status flags with interrupt, and the buffer RAM pointer with data port.
 * Assumes an APB master on sys_clk and link-side event pulses one cycle wide.
 */
`timescale 1ns/10ps
module trr_ctrl
    import trr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic link_rx_start,
    input wire logic link_rx_done,
    input wire logic link_tx_start,
    input wire logic link_tx_done,
    input wire logic probe_answer_seen,
    input wire logic dup_answer_seen,
    output logic soft_reset,
    output logic [7:0] station_id,
    output logic [7:0] probe_id,
    output logic irq
);

    // ==========================================================
    // bus decode
    logic setup;
    logic access;
    logic wr_done;
    logic rd_setup;
    logic mapped;
    logic [7:0] wbyte;

    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign wr_done = access & pwrite;
    assign rd_setup = setup & ~pwrite;
    assign wbyte = pwdata[7:0];
    // no wait states: the answer is ready in the first access cycle
    assign pready = access;

    always_comb begin
        unique case (paddr)
            TRR_OFF_CONFIG, TRR_OFF_STATION, TRR_OFF_PROBE, TRR_OFF_DUPCHK,
            TRR_OFF_BUSCTL, TRR_OFF_PTR_HI, TRR_OFF_PTR_LO, TRR_OFF_DATA,
            TRR_OFF_STATUS, TRR_OFF_IRQ_STAT, TRR_OFF_IRQ_MASK: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    function automatic logic wr_hit(input logic [11:0] off);
        wr_hit = wr_done & (paddr == off);
    endfunction : wr_hit

    // ==========================================================
    // configuration and identifiers
    logic [7:0] config_reg;
    logic [7:0] dupchk_id;
    logic station_zero_pulse;
    logic refine;
    logic anomaly;
    logic id_write;

    assign refine = config_reg[TRR_CFG_REFINE_BIT];
    assign anomaly = config_reg[TRR_CFG_ANOMALY_BIT];
    assign id_write = wr_hit(TRR_OFF_PROBE) | wr_hit(TRR_OFF_STATION);

    // refinement bit comes up cleared so the block starts in legacy mode
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            config_reg <= TRR_CONFIG_RST;
        end else if (wr_hit(TRR_OFF_CONFIG)) begin
            config_reg <= wbyte;
        end
    end

    // identifier registers; station and probe identifiers are seen by the protocol engine, the duplicate check one only by the host
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            station_id <= TRR_ID_RST;
            probe_id <= TRR_ID_RST;
            dupchk_id <= TRR_ID_RST;
        end else begin
            if (wr_hit(TRR_OFF_STATION)) begin
                station_id <= wbyte;
            end
            if (wr_hit(TRR_OFF_PROBE)) begin
                probe_id <= wbyte;
            end
            if (wr_hit(TRR_OFF_DUPCHK)) begin
                dupchk_id <= wbyte;
            end
        end
    end

    // a write of zero to the station identifier fires one soft reset cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            station_zero_pulse <= 1'b0;
        end else begin
            station_zero_pulse <= wr_hit(TRR_OFF_STATION) & (wbyte == TRR_STATION_ZERO);
        end
    end

    // reset control holds the soft reset for as long as it stays high
    assign soft_reset = station_zero_pulse | config_reg[TRR_CFG_RESET_BIT];

    // ==========================================================
    // link status flags
    logic ri_flag;
    logic ta_flag;
    logic probe_hit;
    logic dup_hit;

    // flags go back to one on soft reset; a done pulse beats a start pulse
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ri_flag <= 1'b1;
            ta_flag <= 1'b1;
        end else if (soft_reset) begin
            ri_flag <= 1'b1;
            ta_flag <= 1'b1;
        end else begin
            if (link_rx_done) begin
                ri_flag <= 1'b1;
            end else if (link_rx_start) begin
                ri_flag <= 1'b0;
            end
            if (link_tx_done) begin
                ta_flag <= 1'b1;
            end else if (link_tx_start) begin
                ta_flag <= 1'b0;
            end
        end
    end

    // answers to the probe and duplicate checks linger until discarded;
    // in legacy mode an identifier write leaves the old answer standing
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            probe_hit <= 1'b0;
            dup_hit <= 1'b0;
        end else if (refine && id_write) begin
            probe_hit <= 1'b0;
            dup_hit <= 1'b0;
        end else begin
            probe_hit <= probe_hit | probe_answer_seen;
            dup_hit <= dup_hit | dup_answer_seen;
        end
    end

    // ==========================================================
    // interrupt status and mask
    logic [TRR_IRQ_W-1:0] irq_stat;
    logic [TRR_IRQ_W-1:0] irq_mask;
    logic [TRR_IRQ_W-1:0] irq_event;
    logic [TRR_IRQ_W-1:0] irq_clear;
    logic [TRR_IRQ_W-1:0] stale_clear;
    logic ri_q;
    logic ta_q;

    // edge detectors for the flags returning to one
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ri_q <= 1'b1;
            ta_q <= 1'b1;
        end else begin
            ri_q <= ri_flag;
            ta_q <= ta_flag;
        end
    end

    always_comb begin
        irq_event = '0;
        irq_event[TRR_ST_RI_BIT] = ri_flag & ~ri_q;
        irq_event[TRR_ST_TA_BIT] = ta_flag & ~ta_q;
        irq_event[TRR_ST_PROBE_BIT] = probe_answer_seen;
        irq_event[TRR_ST_DUP_BIT] = dup_answer_seen;
        stale_clear = '0;
        stale_clear[TRR_ST_PROBE_BIT] = refine & id_write;
        stale_clear[TRR_ST_DUP_BIT] = refine & id_write;
    end

    assign irq_clear = wr_hit(TRR_OFF_IRQ_STAT) ? pwdata[TRR_IRQ_W-1:0] : '0;

    // sticky bits: a new event wins over a one written to clear it, but the
    // identifier discard wins so that no stale answer survives the write
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= ((irq_stat & ~irq_clear) | irq_event) & ~stale_clear;
        end
    end

    // legacy mode keeps the mask across a soft reset, which lets the
    // flags returning to one raise a spurious interrupt
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_mask <= TRR_MASK_RST;
        end else if (refine && soft_reset) begin
            irq_mask <= TRR_MASK_RST;
        end else if (wr_hit(TRR_OFF_IRQ_MASK)) begin
            irq_mask <= pwdata[TRR_IRQ_W-1:0];
        end
    end

    assign irq = |(irq_stat & irq_mask);

    // ==========================================================
    // buffer RAM pointer and data port
    logic wide_en;
    logic step_en;
    logic [TRR_RAM_AW-1:0] ram_ptr;
    logic [TRR_RAM_AW-1:0] ptr_step;
    logic data_done;
    logic [15:0] ram_rdata;
    trr_ram_req_t ram_req;

    assign data_done = access & (paddr == TRR_OFF_DATA);

    // bus control holds only the width selector
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wide_en <= 1'b0;
        end else if (wr_hit(TRR_OFF_BUSCTL)) begin
            wide_en <= wbyte[TRR_BUS_WIDE_BIT];
        end
    end

    // step after a data access; the anomaly bit reproduces the affected
    // revision, where a wide transfer always moves the pointer by two
    always_comb begin
        if (step_en) begin
            ptr_step = wide_en ? TRR_STEP_TWO : TRR_STEP_ONE;
        end else if (wide_en && anomaly) begin
            ptr_step = TRR_STEP_TWO;
        end else begin
            ptr_step = TRR_STEP_NONE;
        end
    end

    // pointer registers; a host on the affected revision reloads them
    // before every repeated access to the same byte
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ram_ptr <= '0;
            step_en <= 1'b0;
        end else if (wr_hit(TRR_OFF_PTR_HI)) begin
            ram_ptr[TRR_RAM_AW-1:8] <= wbyte[TRR_RAM_AW-9:0];
            step_en <= wbyte[TRR_PTR_STEP_BIT];
        end else if (wr_hit(TRR_OFF_PTR_LO)) begin
            ram_ptr[7:0] <= wbyte;
        end else if (data_done) begin
            ram_ptr <= ram_ptr + ptr_step;
        end
    end

    // narrow mode moves a single byte; wide mode moves two
    always_comb begin
        ram_req.we = wr_hit(TRR_OFF_DATA);
        ram_req.wide = wide_en;
        ram_req.addr = ram_ptr;
        ram_req.wdata = pwdata[15:0];
    end

    trr_ram u_ram (
        .sys_clk(sys_clk),
        .req(ram_req),
        .rdata(ram_rdata)
    );

    // ==========================================================
    // read data, captured in the setup cycle so it leaves a flop
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = '0;
        unique case (paddr)
            TRR_OFF_CONFIG: rd_mux[7:0] = config_reg;
            TRR_OFF_STATION: rd_mux[7:0] = station_id;
            TRR_OFF_PROBE: rd_mux[7:0] = probe_id;
            TRR_OFF_DUPCHK: rd_mux[7:0] = dupchk_id;
            TRR_OFF_BUSCTL: rd_mux[TRR_BUS_WIDE_BIT] = wide_en;
            TRR_OFF_PTR_HI: begin
                rd_mux[TRR_RAM_AW-9:0] = ram_ptr[TRR_RAM_AW-1:8];
                rd_mux[TRR_PTR_STEP_BIT] = step_en;
            end
            TRR_OFF_PTR_LO: rd_mux[7:0] = ram_ptr[7:0];
            TRR_OFF_DATA: begin
                rd_mux[7:0] = ram_rdata[7:0];
                rd_mux[15:8] = wide_en ? ram_rdata[15:8] : 8'h00;
            end
            TRR_OFF_STATUS: begin
                rd_mux[TRR_ST_RI_BIT] = ri_flag;
                rd_mux[TRR_ST_TA_BIT] = ta_flag;
                rd_mux[TRR_ST_PROBE_BIT] = probe_hit;
                rd_mux[TRR_ST_DUP_BIT] = dup_hit;
            end
            TRR_OFF_IRQ_STAT: rd_mux[TRR_IRQ_W-1:0] = irq_stat;
            TRR_OFF_IRQ_MASK: rd_mux[TRR_IRQ_W-1:0] = irq_mask;
            default: rd_mux = '0;
        endcase
    end

    // read data and error flag are both fixed by the setup cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prdata <= '0;
        end else if (rd_setup) begin
            prdata <= rd_mux;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pslverr <= 1'b0;
        end else if (setup) begin
            pslverr <= ~mapped;
        end else if (!psel) begin
            pslverr <= 1'b0;
        end
    end

endmodule : trr_ctrl

// ### src/trr_pkg.sv
/*
 * Shared constants and types of the station controller register block:
 * register offsets, field positions, reset values and the RAM request carrier.
 * Assumes an APB master with 32-bit data and byte addresses on paddr.
 */
//
// Behaviour
// - with refinements on, station and probe identifier writes discard stale probe and duplicate results
// - refinement enable resets to zero, legacy; one turns on the fixes
// - with refinements on, mask clears on hard and on soft reset
// - soft reset when station identifier written zero or reset control high
// - soft reset returns receive-inhibited and transmitter-available flags to one
// - wide access enable sits in bit seven of bus control
// - wide access off gives 8-bit data transfers, on gives 16-bit
// - pointer step enable sits in bit six of pointer high
// - step enable one advances the RAM pointer after each data access
// - step enable zero leaves the RAM pointer unchanged after data access
// - affected revision, wide on: pointer advances two even without step enable
package trr_pkg;

    // ==========================================================
    // register offsets (byte addresses)
    localparam logic [11:0] TRR_OFF_CONFIG = 12'h000;
    localparam logic [11:0] TRR_OFF_STATION = 12'h004;
    localparam logic [11:0] TRR_OFF_PROBE = 12'h008;
    localparam logic [11:0] TRR_OFF_DUPCHK = 12'h00c;
    localparam logic [11:0] TRR_OFF_BUSCTL = 12'h010;
    localparam logic [11:0] TRR_OFF_PTR_HI = 12'h014;
    localparam logic [11:0] TRR_OFF_PTR_LO = 12'h018;
    localparam logic [11:0] TRR_OFF_DATA = 12'h01c;
    localparam logic [11:0] TRR_OFF_STATUS = 12'h020;
    localparam logic [11:0] TRR_OFF_IRQ_STAT = 12'h024;
    localparam logic [11:0] TRR_OFF_IRQ_MASK = 12'h028;

    // ==========================================================
    // field positions
    localparam int TRR_CFG_RESET_BIT = 0;
    localparam int TRR_CFG_REFINE_BIT = 1;
    localparam int TRR_CFG_ANOMALY_BIT = 2;
    localparam int TRR_BUS_WIDE_BIT = 7;
    localparam int TRR_PTR_STEP_BIT = 6;
    localparam int TRR_ST_RI_BIT = 0;
    localparam int TRR_ST_TA_BIT = 1;
    localparam int TRR_ST_PROBE_BIT = 2;
    localparam int TRR_ST_DUP_BIT = 3;

    // ==========================================================
    // sizes and reset values
    localparam int TRR_RAM_AW = 11;
    localparam int TRR_IRQ_W = 4;
    localparam logic [7:0] TRR_CONFIG_RST = 8'h00;
    localparam logic [7:0] TRR_STATION_ZERO = 8'h00;
    localparam logic [7:0] TRR_ID_RST = 8'h00;
    localparam logic [TRR_IRQ_W-1:0] TRR_MASK_RST = 4'h0;
    localparam logic [TRR_RAM_AW-1:0] TRR_STEP_ONE = 11'h001;
    localparam logic [TRR_RAM_AW-1:0] TRR_STEP_TWO = 11'h002;
    localparam logic [TRR_RAM_AW-1:0] TRR_STEP_NONE = 11'h000;

    // one RAM access as seen by the buffer memory
    typedef struct packed {
        logic we;
        logic wide;
        logic [TRR_RAM_AW-1:0] addr;
        logic [15:0] wdata;
    } trr_ram_req_t;

endpackage : trr_pkg

// ### src/trr_ram.sv
/*
 * Packet buffer memory, 2K bytes, with one byte or two-byte access.
 * Assumes the caller keeps requests synchronous to sys_clk; read is asynchronous.
 */
`timescale 1ns/10ps
module trr_ram
    import trr_pkg::*;
(
    input wire logic sys_clk,
    input wire trr_ram_req_t req,
    output logic [15:0] rdata
);

    // ==========================================================
    // storage
    logic [7:0] mem [0:(1<<TRR_RAM_AW)-1];
    logic [TRR_RAM_AW-1:0] addr_hi;

    // the second byte wraps at the top of the buffer
    assign addr_hi = req.addr + TRR_STEP_ONE;
    assign rdata = {mem[addr_hi], mem[req.addr]};

    // write low byte always, high byte only on a wide transfer
    always_ff @(posedge sys_clk) begin
        if (req.we) begin
            mem[req.addr] <= req.wdata[7:0];
            if (req.wide) begin
                mem[addr_hi] <= req.wdata[15:8];
            end
        end
    end

endmodule : trr_ram

// ### bench/trr_ctrl_checker.sv
/* checker of the controller register block: bus phases, identifiers, soft reset, mask.
   assumes it is bound to trr_ctrl and sees nothing but its ports. */
`timescale 1ns/10ps
module trr_ctrl_checker
    import trr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic soft_reset,
    input wire logic [7:0] station_id,
    input wire logic [7:0] probe_id,
    input wire logic irq
);
    // ==========
    // helper terms
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic wr_acc;
    logic soft_cause;
    assign wr_acc = psel && penable && pwrite;
    // either trigger of a soft reset, seen at the access edge
    assign soft_cause = wr_acc && ((paddr == TRR_OFF_STATION && pwdata[7:0] == 8'h00)
        || (paddr == TRR_OFF_CONFIG && pwdata[TRR_CFG_RESET_BIT]));
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_acc;
        psel && penable;
    endsequence
    property p_ready;
        pready == (psel && penable);
    endproperty
    property p_unmapped;
        s_setup ##0 (!pwrite && paddr > TRR_OFF_IRQ_MASK) ##1 s_acc |-> pslverr && prdata == 32'h0;
    endproperty
    property p_mapped;
        s_setup ##0 (paddr[1:0] == 2'b00 && paddr <= TRR_OFF_IRQ_MASK) ##1 s_acc |-> !pslverr;
    endproperty
    property p_station;
        wr_acc && paddr == TRR_OFF_STATION |=> {24'h0, station_id} == ($past(pwdata) & 32'hff);
    endproperty
    property p_probe;
        wr_acc && paddr == TRR_OFF_PROBE |=> {24'h0, probe_id} == ($past(pwdata) & 32'hff);
    endproperty
    property p_soft_zero;
        wr_acc && paddr == TRR_OFF_STATION && pwdata[7:0] == 8'h00 |=> soft_reset;
    endproperty
    // the control bit is a level, so the reset must still stand a cycle later
    property p_soft_hold;
        wr_acc && paddr == TRR_OFF_CONFIG && pwdata[TRR_CFG_RESET_BIT] |=> soft_reset [*2];
    endproperty
    property p_soft_cause;
        $rose(soft_reset) |-> $past(soft_cause);
    endproperty
    property p_mask_off;
        wr_acc && paddr == TRR_OFF_IRQ_MASK && pwdata[3:0] == 4'h0 |=> !irq;
    endproperty
    a_ready: assert property (p_ready) else $error("pready differs from access phase");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
    a_mapped: assert property (p_mapped) else $error("mapped access refused");
    a_station: assert property (p_station) else $error("station id not written");
    a_probe: assert property (p_probe) else $error("probe id not written");
    a_soft_zero: assert property (p_soft_zero) else $error("no soft reset on zero id");
    a_soft_hold: assert property (p_soft_hold) else $error("soft reset bit not held");
    a_soft_cause: assert property (p_soft_cause) else $error("soft reset without cause");
    a_mask_off: assert property (p_mask_off) else $error("irq with all masked");
endmodule : trr_ctrl_checker

bind trr_ctrl trr_ctrl_checker u_chk (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .soft_reset, .station_id, .probe_id, .irq);

// ### bench/trr_host.sv
/* host model: APB master that reaches the controller registers.
   assumes sys_clk from the bench; waits for pready however long it takes. */
`timescale 1ns/10ps
module trr_host
    import trr_pkg::*;
(
    input wire logic sys_clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // ==========
    // idle bus
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end

    // one transfer; idle cycles in front make a slow host
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
        input int idle, output logic [31:0] rd, output logic err);
        repeat (idle) @(posedge sys_clk);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d; // released data must not look valid
    endtask : xfer

    // repeated query of one location reloads the pointer every time
    task automatic peek(input logic [7:0] hi, input logic [7:0] lo, output logic [31:0] rd);
        logic e;
        xfer(1'b1, TRR_OFF_PTR_HI, {24'h0, hi}, 0, rd, e);
        xfer(1'b1, TRR_OFF_PTR_LO, {24'h0, lo}, 0, rd, e);
        xfer(1'b0, TRR_OFF_DATA, 32'h0, 0, rd, e);
    endtask : peek
endmodule : trr_host

// ### bench/tb_trr_ctrl.sv
/* self-checking bench of trr_ctrl with a byte RAM model and expected flags.
   assumes trr_host and the bound checker are compiled before it. */
`timescale 1ns/10ps
module tb_trr_ctrl
    import trr_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, soft_reset, irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] station_id, probe_id;
    logic [5:0] ev = 6'h00;
    logic [31:0] seed = 32'h30a0;
    int n_errors = 0;
    int cmp_count = 0;
    int mem [2048];

    // ==========
    // clock and parts
    always #5 sys_clk = ~sys_clk;
    trr_host host (.sys_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr);
    trr_ctrl dut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .link_rx_start(ev[0]), .link_rx_done(ev[1]), .link_tx_start(ev[2]),
        .link_tx_done(ev[3]), .probe_answer_seen(ev[4]), .dup_answer_seen(ev[5]),
        .soft_reset, .station_id, .probe_id, .irq);

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rnd() & 3, rd, err);
    endtask : wr
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        host.xfer(1'b0, a, 32'h0, rnd() & 3, rd, err);
        chk(rd, exp);
    endtask : rdc
    // link events are one-cycle pulses
    task automatic pulse(input logic [5:0] m);
        @(posedge sys_clk);
        ev <= m;
        @(posedge sys_clk);
        ev <= 6'h00;
    endtask : pulse
    task automatic close_out();
        $display("compares=%0d errors=%0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    // the tests need well under a thousand cycles; this is far beyond that
    initial begin
        #300000;
        n_errors++;
        close_out();
    end

    // ==========
    // scenarios
    initial begin
        int x, w, s, an, p, st, d;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        rdc(TRR_OFF_CONFIG, 32'h0);
        rdc(TRR_OFF_STATUS, 32'h3);
        // every mix of wide access, step enable and revision anomaly
        for (x = 0; x < 8; x++) begin
            w = x & 1;
            s = (x >> 1) & 1;
            an = x >> 2;
            p = rnd() & 2047;
            d = rnd() & 16'hffff;
            st = s ? (w ? 2 : 1) : ((w && an) ? 2 : 0);
            wr(TRR_OFF_CONFIG, an << TRR_CFG_ANOMALY_BIT);
            wr(TRR_OFF_BUSCTL, w << TRR_BUS_WIDE_BIT);
            rdc(TRR_OFF_BUSCTL, w << TRR_BUS_WIDE_BIT);
            wr(TRR_OFF_PTR_HI, (s << TRR_PTR_STEP_BIT) | (p >> 8));
            wr(TRR_OFF_PTR_LO, p & 255);
            wr(TRR_OFF_DATA, d);
            mem[p] = d & 255;
            if (w) mem[(p + 1) & 2047] = d >> 8;
            host.xfer(1'b0, TRR_OFF_PTR_LO, 32'h0, 0, rd, err);
            chk(rd, (p + st) & 255);
            host.xfer(1'b0, TRR_OFF_PTR_HI, 32'h0, 0, rd, err);
            chk(rd & 32'h47, (s << 6) | (((p + st) & 2047) >> 8));
            repeat (2) begin
                host.peek(p >> 8, p & 255, rd);
                chk(rd, (w ? (mem[(p + 1) & 2047] << 8) : 0) | mem[p]);
            end
        end
        // soft reset in legacy and refined mode
        for (x = 0; x < 2; x++) begin
            wr(TRR_OFF_CONFIG, x << TRR_CFG_REFINE_BIT);
            wr(TRR_OFF_IRQ_STAT, 32'hf);
            wr(TRR_OFF_IRQ_MASK, 32'hf);
            pulse(6'h05);
            rdc(TRR_OFF_STATUS, 32'h0);
            wr(TRR_OFF_STATION, 32'h0);
            rdc(TRR_OFF_STATUS, 32'h3);
            rdc(TRR_OFF_IRQ_MASK, x ? 32'h0 : 32'hf);
            chk(irq, !x);
            wr(TRR_OFF_IRQ_MASK, 32'hf);
            @(negedge sys_clk);
            chk(irq, 1);
            // a mask of zero must silence the pending status bits
            wr(TRR_OFF_IRQ_MASK, 32'h0);
            @(negedge sys_clk);
            chk(irq, 0);
            wr(TRR_OFF_IRQ_MASK, 32'hf);
            @(negedge sys_clk);
            chk(irq, 1);
            wr(TRR_OFF_IRQ_STAT, 32'hf);
            @(negedge sys_clk);
            chk(irq, 0);
            wr(TRR_OFF_CONFIG, (x << TRR_CFG_REFINE_BIT) | 1);
            @(negedge sys_clk);
            chk(soft_reset, 1);
            wr(TRR_OFF_CONFIG, x << TRR_CFG_REFINE_BIT);
            @(negedge sys_clk);
            chk(soft_reset, 0);
        end
        // identifier writes against stale probe and duplicate answers
        for (x = 0; x < 3; x++) begin
            wr(TRR_OFF_CONFIG, (x ? 32'h1 : 32'h0) << TRR_CFG_REFINE_BIT);
            wr(TRR_OFF_PROBE, rnd() & 255);
            pulse(6'h30);
            rdc(TRR_OFF_STATUS, 32'hf);
            d = (rnd() & 254) | 1;
            wr(x == 2 ? TRR_OFF_STATION : TRR_OFF_PROBE, d);
            rdc(TRR_OFF_STATUS, x ? 32'h3 : 32'hf);
            rdc(TRR_OFF_IRQ_STAT, x ? 32'h0 : 32'hc);
            chk(x == 2 ? station_id : probe_id, d);
            wr(TRR_OFF_IRQ_STAT, 32'hf);
        end
        // hard reset in mid-run, with refinements on and the mask set
        wr(TRR_OFF_CONFIG, 32'h1 << TRR_CFG_REFINE_BIT);
        wr(TRR_OFF_IRQ_MASK, 32'hf);
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        rdc(TRR_OFF_IRQ_MASK, 32'h0);
        rdc(TRR_OFF_CONFIG, 32'h0);
        rdc(TRR_OFF_STATUS, 32'h3);
        host.xfer(1'b0, 12'h02c, 32'h0, 0, rd, err);
        chk(rd, 32'h0);
        chk(err, 1);
        close_out();
    end
endmodule : tb_trr_ctrl
